// ### rtl/dsdc_top.sv
// Purpose: converter control with AXI4-Lite registers
// Assumes: modulator bits are synchronous to SYS_CLK
// Notes:   both channels share one modulator sample strobe
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dsdc_top import dsdc_pkg::*; (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// modulators
	output logic MOD_STROBE,
	input wire logic I_MOD_BIT,
	input wire logic V_MOD_BIT,
	// analog front end control
	output logic [1:0] VT_SRC_SEL,
	output logic ATTEN_EN,
	output logic GROUND_SWITCH_PIN_CONNECT,
	output logic GROUND_SWITCH_PIN_VIA_RES,
	// events
	output logic EVT_COUNT,
	output logic EVT_THRESH
);

	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta_n, rst_n; // two-stage release

	// reset enters asynchronously, leaves synchronously
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ****************************************
	// byte lane merge
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0;
		for (int b = 0; b < 4; b++) m[b*8 +: 8] = {8{strb[b]}};
		return (old & ~m) | (data & m);
	endfunction

	// ****************************************
	// bus slave state
	// ****************************************
	logic aw_held, w_held; // address and data captured
	logic [ADDR_W-1:0] aw_addr; // captured write address
	logic [31:0] w_data; // captured write data
	logic [3:0] w_strb; // captured byte enables
	logic do_write; // register write this cycle
	logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [7:0] wa; // word-aligned write address
	logic [31:0] rd_word; // read mux
	logic rd_hit, wr_hit; // address decodes

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] cfg_reg; // converter_config_reg
	logic [7:0] mode_reg; // converter_mode_reg
	logic [7:0] hv_reg; // high_voltage_config_one
	logic [19:0] i_dec, v_dec; // samples per result
	logic [7:0] shift_reg; // [3:0] current, [7:4] voltage
	logic [15:0] count_limit, count_val; // conversion counter
	logic [15:0] threshold; // signed compare level
	logic [31:0] acc; // result accumulator
	logic [2:0] st_flags; // sticky count, threshold, fast
	logic i_restart, v_restart; // settle restart pulses
	logic [7:0] wr_mode; // merged mode write value
	logic [7:0] clr_mask; // status bits cleared by a write
	logic [8:0] mod_div; // modulator strobe divider, wide enough for the full period
	dsdc_chan_cfg_type i_cfg, v_cfg;
	dsdc_chan_out_type i_out, v_out;
	dsdc_src_type next_src;

	assign do_write = aw_held && w_held && !S_AXI_BVALID;
	assign wa = {aw_addr[7:2], 2'h0};
	assign wr_mode = 8'(merge({24'h0, mode_reg}, w_data, w_strb));
	assign clr_mask = (do_write && wa == ADDR_STAT) ? w_data[7:0] : 8'h0;

	// write decode: read-only registers take writes silently but answer error
	always_comb begin
		case (wa)
			ADDR_CFG, ADDR_MODE, ADDR_HV, ADDR_IDEC, ADDR_VDEC: wr_hit = 1'b1;
			ADDR_SHIFT, ADDR_CLIM, ADDR_THR, ADDR_STAT: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// next handshake state; capture and release per channel
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_bvalid = S_AXI_BVALID;
		next_rvalid = S_AXI_RVALID;
		if (S_AXI_AWREADY && S_AXI_AWVALID) next_aw_held = 1'b1;
		if (S_AXI_WREADY && S_AXI_WVALID) next_w_held = 1'b1;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
		end
		if (S_AXI_BVALID && S_AXI_BREADY) next_bvalid = 1'b0;
		if (S_AXI_ARREADY && S_AXI_ARVALID) next_rvalid = 1'b1;
		if (S_AXI_RVALID && S_AXI_RREADY) next_rvalid = 1'b0;
	end

	// write channel flops; readies drop while a write is pending
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (S_AXI_AWREADY && S_AXI_AWVALID) aw_addr <= S_AXI_AWADDR;
			if (S_AXI_WREADY && S_AXI_WVALID) begin
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			S_AXI_AWREADY <= !next_aw_held && !next_bvalid;
			S_AXI_WREADY <= !next_w_held && !next_bvalid;
			S_AXI_BVALID <= next_bvalid;
			if (do_write) S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// read mux, reserved bits read zero
	always_comb begin
		rd_hit = 1'b1;
		case ({S_AXI_ARADDR[7:2], 2'h0})
			ADDR_CFG: rd_word = {24'h0, cfg_reg};
			ADDR_MODE: rd_word = {24'h0, mode_reg};
			ADDR_HV: rd_word = {24'h0, hv_reg};
			ADDR_IDEC: rd_word = {12'h0, i_dec};
			ADDR_VDEC: rd_word = {12'h0, v_dec};
			ADDR_SHIFT: rd_word = {24'h0, shift_reg};
			ADDR_CLIM: rd_word = {16'h0, count_limit};
			ADDR_CVAL: rd_word = {16'h0, count_val};
			ADDR_THR: rd_word = {16'h0, threshold};
			ADDR_ACC: rd_word = acc;
			ADDR_IRES: rd_word = {16'h0, i_out.data};
			ADDR_VRES: rd_word = {16'h0, v_out.data};
			ADDR_STAT: rd_word = {27'h0, v_out.err, i_out.err, st_flags};
			default: begin
				rd_word = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	// read channel; data captured when the address is taken
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !next_rvalid;
			S_AXI_RVALID <= next_rvalid;
			if (S_AXI_ARREADY && S_AXI_ARVALID) begin
				S_AXI_RDATA <= rd_word;
				S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// control registers
	// ****************************************

	// software-written settings
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= RST_CFG;
			mode_reg <= RST_MODE;
			hv_reg <= RST_HV;
			i_dec <= RST_DEC;
			v_dec <= RST_DEC;
			shift_reg <= RST_SHIFT;
			count_limit <= RST_CLIM;
			threshold <= RST_THR;
		end else if (do_write) begin
			case (wa)
				ADDR_CFG: cfg_reg <= 8'(merge({24'h0, cfg_reg}, w_data, w_strb));
				ADDR_MODE: mode_reg <= wr_mode;
				ADDR_HV: hv_reg <= 8'(merge({24'h0, hv_reg}, w_data, w_strb)); // see R11
				ADDR_IDEC: i_dec <= 20'(merge({12'h0, i_dec}, w_data, w_strb));
				ADDR_VDEC: v_dec <= 20'(merge({12'h0, v_dec}, w_data, w_strb));
				ADDR_SHIFT: shift_reg <= 8'(merge({24'h0, shift_reg}, w_data, w_strb));
				ADDR_CLIM: count_limit <= 16'(merge({16'h0, count_limit}, w_data, w_strb));
				ADDR_THR: threshold <= 16'(merge({16'h0, threshold}, w_data, w_strb));
				default: ;
			endcase
		end
	end

	// a config write starts both channels afresh; a new source resettles voltage
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			i_restart <= 1'b0;
			v_restart <= 1'b0;
		end else begin
			i_restart <= do_write && wa == ADDR_CFG; // see R07
			v_restart <= do_write && (wa == ADDR_CFG || (wa == ADDR_MODE && wr_mode[1:0] != mode_reg[1:0])); // see R10
		end
	end

	// ****************************************
	// channels
	// ****************************************

	// modulator sample strobe, shared by both channels
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			mod_div <= 9'h0;
			MOD_STROBE <= 1'b0;
		end else begin
			MOD_STROBE <= (mod_div == 9'(MOD_DIV - 1));
			mod_div <= (mod_div == 9'(MOD_DIV - 1)) ? 9'h0 : mod_div + 9'h1;
		end
	end

	always_comb begin
		i_cfg = '{cfg_reg[CFG_I_EN], cfg_reg[CFG_CHOP], cfg_reg[CFG_LP], cfg_reg[CFG_FAST], i_restart,
			shift_reg[3:0], i_dec};
		v_cfg = '{cfg_reg[CFG_V_EN], cfg_reg[CFG_CHOP], 1'b0, 1'b0, v_restart, shift_reg[7:4], v_dec}; // see R09
	end

	dsdc_chan u_i_chan (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.mod_ce(MOD_STROBE),
		.mod_bit(I_MOD_BIT),
		.cfg(i_cfg),
		.res(i_out)
	); // see R01

	dsdc_chan u_v_chan (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.mod_ce(MOD_STROBE),
		.mod_bit(V_MOD_BIT),
		.cfg(v_cfg),
		.res(v_out)
	); // see R01

	// ****************************************
	// counter, comparator, accumulator
	// ****************************************

	// conversion counter wraps at the limit and fires an event
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			count_val <= 16'h0;
			EVT_COUNT <= 1'b0;
		end else begin
			EVT_COUNT <= 1'b0;
			if (!cfg_reg[CFG_I_EN]) count_val <= 16'h0;
			else if (i_out.valid) begin
				if ({1'b0, count_val} + 17'h1 >= {1'b0, count_limit}) begin // see R03
					count_val <= 16'h0;
					EVT_COUNT <= 1'b1;
				end else count_val <= count_val + 16'h1;
			end
		end
	end

	// threshold compare on signed results
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) EVT_THRESH <= 1'b0;
		else EVT_THRESH <= i_out.valid && ($signed(i_out.data) > $signed(threshold)); // see R04
	end

	// accumulator cleared while disabled; wraps silently on overflow
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) acc <= 32'h0;
		else if (!cfg_reg[CFG_ACC]) acc <= 32'h0;
		else if (i_out.valid) acc <= acc + {{16{i_out.data[15]}}, i_out.data}; // see R05
	end

	// sticky status; a set in the clearing cycle survives
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) st_flags <= 3'h0;
		else st_flags <= (st_flags & ~clr_mask[2:0]) | {i_out.fast_or, EVT_THRESH, EVT_COUNT}; // see R06
	end

	// ****************************************
	// front end control
	// ****************************************

	// source selection, unused code falls to the chip sensor
	always_comb begin
		case (mode_reg[1:0])
			2'h0: next_src = DSDC_SRC_VOLT;
			2'h1: next_src = DSDC_SRC_EXT_TEMP;
			default: next_src = DSDC_SRC_CHIP_TEMP;
		endcase
	end

	// ground switch: both switches open means floating
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			VT_SRC_SEL <= 2'h0;
			ATTEN_EN <= 1'b0;
			GROUND_SWITCH_PIN_CONNECT <= 1'b0;
			GROUND_SWITCH_PIN_VIA_RES <= 1'b0;
		end else begin
			VT_SRC_SEL <= next_src; // see R08
			ATTEN_EN <= hv_reg[HV_ATTEN];
			GROUND_SWITCH_PIN_CONNECT <= cfg_reg[CFG_GND] && !mode_reg[MODE_RES]; // see R12, R13
			GROUND_SWITCH_PIN_VIA_RES <= cfg_reg[CFG_GND] && mode_reg[MODE_RES]; // see R12, R14
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_gnd_float: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // see R12
		!cfg_reg[CFG_GND] |=> (!GROUND_SWITCH_PIN_CONNECT && !GROUND_SWITCH_PIN_VIA_RES))
		else $error("ground switch not floating");
	a_gnd_direct: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // see R13
		(cfg_reg[CFG_GND] && !mode_reg[MODE_RES]) |=> (GROUND_SWITCH_PIN_CONNECT && !GROUND_SWITCH_PIN_VIA_RES))
		else $error("ground switch not direct");
	a_gnd_resist: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // see R14
		(cfg_reg[CFG_GND] && mode_reg[MODE_RES]) |=> (!GROUND_SWITCH_PIN_CONNECT && GROUND_SWITCH_PIN_VIA_RES))
		else $error("ground switch not via resistor");
	a_count_event: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // see R03
		(i_out.valid && cfg_reg[CFG_I_EN] && count_val + 16'h1 == count_limit) |=> (EVT_COUNT && count_val == 16'h0)
			##1 st_flags[ST_COUNT])
		else $error("count limit missed");
	a_thresh_event: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // see R04
		EVT_THRESH |-> $past(i_out.valid) && ($signed($past(i_out.data)) > $signed($past(threshold))))
		else $error("threshold event without cause");
	a_acc_update: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // see R05
		(cfg_reg[CFG_ACC] && i_out.valid) |=> acc == $past(acc) + {{16{$past(i_out.data[15])}}, $past(i_out.data)})
		else $error("accumulator missed a result");
	a_fast_flag: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // see R06
		i_out.fast_or |=> st_flags[ST_FAST])
		else $error("fast over-range not flagged");

endmodule
`default_nettype wire

// ### rtl/dsdc_pkg.sv
// Operation
// R01 - two independent channels, 16-bit results each
// R02 - current rate 4 Hz-8 kHz, low power 1 Hz-2 kHz
// R03 - count results, event at programmed count
// R04 - event when result exceeds threshold
// R05 - accumulate results into 32-bit sum when enabled
// R06 - software-enabled fast over-range detection
// R07 - settled after three conversions, two with chop
// R08 - voltage channel source: voltage, external, chip temperature
// R09 - voltage channel rate 4 Hz-8 kHz, same filter
// R10 - source switch needs three conversions to settle; with chop on, the code delivers the second conversion after a switch
// R11 - software sets attenuator enable before battery conversion
// R12 - connect bit low leaves ground switch floating
// R13 - connect high, select low: direct to ground
// R14 - both high: ground through internal resistor
// R15 - out-of-range clamps to full scale, sets error
// R16 - one-cycle result strobe drives counter, compare, accumulate
//
// Purpose: constants and carriers shared by the converter control block
// Assumes: 200 MHz system clock, 512 kHz modulator sample rate
// Notes:   offsets are byte addresses on the register bus

package dsdc_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 200_000_000; // system clock rate
	localparam int MOD_RATE_HZ = 512_000; // modulator sample rate
	localparam int MOD_DIV = CLK_HZ / MOD_RATE_HZ; // clocks per sample, rounded down
	localparam int RATE_MAX_HZ = 8_000; // fastest output rate
	localparam int RATE_MIN_HZ = 4; // slowest output rate
	localparam logic [19:0] DEC_MIN = 20'(MOD_RATE_HZ / RATE_MAX_HZ); // samples per result, fastest
	localparam logic [19:0] DEC_MAX = 20'(MOD_RATE_HZ / RATE_MIN_HZ); // samples per result, slowest
	localparam logic [1:0] LP_LAST = 2'h3; // low power takes one sample in four
	localparam logic [1:0] SETTLE_NOCHOP = 2'h3; // conversions to settle, chop off
	localparam logic [1:0] SETTLE_CHOP = 2'h2; // conversions to settle, chop on
	localparam logic [7:0] FAST_RUN = 8'h20; // equal modulator bits meaning over-range

	// ****************************************
	// full scale
	// ****************************************
	localparam logic signed [20:0] FS_POS = 21'h007fff; // positive full scale
	localparam logic signed [20:0] FS_NEG = 21'h1f8000; // negative full scale

	// ****************************************
	// register offsets
	// ****************************************
	localparam int ADDR_W = 8; // bus address width
	localparam logic [7:0] ADDR_CFG = 8'h00; // converter_config_reg
	localparam logic [7:0] ADDR_MODE = 8'h04; // converter_mode_reg
	localparam logic [7:0] ADDR_HV = 8'h08; // high_voltage_config_one
	localparam logic [7:0] ADDR_IDEC = 8'h0c; // current decimation
	localparam logic [7:0] ADDR_VDEC = 8'h10; // voltage decimation
	localparam logic [7:0] ADDR_SHIFT = 8'h14; // result scaling shifts
	localparam logic [7:0] ADDR_CLIM = 8'h18; // count limit
	localparam logic [7:0] ADDR_CVAL = 8'h1c; // count value, read only
	localparam logic [7:0] ADDR_THR = 8'h20; // threshold
	localparam logic [7:0] ADDR_ACC = 8'h24; // accumulator, read only
	localparam logic [7:0] ADDR_IRES = 8'h28; // current result, read only
	localparam logic [7:0] ADDR_VRES = 8'h2c; // voltage result, read only
	localparam logic [7:0] ADDR_STAT = 8'h30; // status, write one to clear

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int CFG_I_EN = 0, CFG_V_EN = 1, CFG_CHOP = 2, CFG_LP = 3;
	localparam int CFG_ACC = 4, CFG_FAST = 5, CFG_GND = 7;
	localparam int MODE_RES = 6; // ground switch resistor select
	localparam int HV_ATTEN = 7; // battery attenuator enable
	localparam int ST_COUNT = 0, ST_THR = 1, ST_FAST = 2, ST_IERR = 3, ST_VERR = 4;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_HV = 8'h00;
	localparam logic [19:0] RST_DEC = 20'h00400;
	localparam logic [7:0] RST_SHIFT = 8'h44;
	localparam logic [15:0] RST_CLIM = 16'h0001;
	localparam logic [15:0] RST_THR = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {DSDC_SRC_VOLT, DSDC_SRC_EXT_TEMP, DSDC_SRC_CHIP_TEMP} dsdc_src_type;

	typedef struct packed {
		logic en; // channel running
		logic chop; // chop mode, shorter settling
		logic low_power; // quarter sample rate
		logic fast_en; // fast over-range detect on
		logic restart; // one-cycle pulse, restarts settling
		logic [3:0] shift; // right shift of the raw sum
		logic [19:0] dec; // modulator samples per result
	} dsdc_chan_cfg_type;

	typedef struct packed {
		logic valid; // one-cycle result strobe
		logic err; // last result was clamped
		logic fast_or; // one-cycle over-range pulse
		logic [15:0] data; // signed result
	} dsdc_chan_out_type;

endpackage

// ### rtl/dsdc_chan.sv
// Purpose: decimation, settling and clamping of one converter channel
// Assumes: mod_ce is a one-cycle pulse at the modulator sample rate
// Notes:   a simple integrate-and-dump sum stands in for the filter core
`timescale 1ns/1ps
`default_nettype none

module dsdc_chan import dsdc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// modulator side
	input wire logic mod_ce,
	input wire logic mod_bit,
	// control and result
	input wire dsdc_chan_cfg_type cfg,
	output var dsdc_chan_out_type res
);

	logic [1:0] lp_cnt; // low power sample divider
	logic [19:0] dec_cnt; // samples in current window
	logic signed [20:0] sum; // bipolar bit sum
	logic [1:0] settled; // conversions since start, saturating
	logic [7:0] run_len; // equal-bit run length
	logic last_bit; // previous modulator bit
	logic [19:0] dec_eff; // window length held to the legal range
	logic samp, window_end, deliver;
	logic signed [20:0] next_sum, scaled;
	logic [1:0] need; // conversions needed to settle

	assign dec_eff = (cfg.dec < DEC_MIN) ? DEC_MIN : (cfg.dec > DEC_MAX) ? DEC_MAX : cfg.dec; // see R02
	assign samp = mod_ce && cfg.en && (!cfg.low_power || lp_cnt == LP_LAST); // see R02
	assign window_end = samp && (dec_cnt == dec_eff - 20'h1);
	assign next_sum = mod_bit ? sum + 21'sh1 : sum - 21'sh1;
	assign scaled = next_sum >>> cfg.shift;
	assign need = cfg.chop ? SETTLE_CHOP : SETTLE_NOCHOP;
	assign deliver = window_end && (settled >= need - 2'h1); // see R07, R10

	// low power divider
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) lp_cnt <= 2'h0;
		else if (!cfg.en) lp_cnt <= 2'h0;
		else if (mod_ce) lp_cnt <= lp_cnt + 2'h1;
	end

	// integrate and dump; a restart drops the partial window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_cnt <= 20'h0;
			sum <= 21'sh0;
		end else if (!cfg.en || cfg.restart || window_end) begin
			dec_cnt <= 20'h0;
			sum <= 21'sh0;
		end else if (samp) begin
			dec_cnt <= dec_cnt + 20'h1;
			sum <= next_sum;
		end
	end

	// settling count, restarted by start or source switch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) settled <= 2'h0;
		else if (!cfg.en || cfg.restart) settled <= 2'h0; // see R10
		else if (window_end && settled != 2'h3) settled <= settled + 2'h1;
	end

	// result with clamp; error follows each written result
	// every field of res is written here, so the output has a single writer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res.valid <= 1'b0;
			res.fast_or <= 1'b0;
			res.err <= 1'b0;
			res.data <= 16'h0;
		end else begin
			res.valid <= deliver; // see R16
			res.fast_or <= samp && cfg.fast_en && mod_bit == last_bit && run_len == FAST_RUN - 8'h1; // see R06
			if (deliver) begin
				res.err <= (scaled > FS_POS) || (scaled < FS_NEG); // see R15
				if (scaled > FS_POS) res.data <= FS_POS[15:0];
				else if (scaled < FS_NEG) res.data <= FS_NEG[15:0];
				else res.data <= scaled[15:0]; // see R01
			end
		end
	end

	// fast over-range: long run of one polarity, long before the window ends
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_len <= 8'h0;
			last_bit <= 1'b0;
		end else begin
			if (!cfg.en) run_len <= 8'h0;
			else if (samp) begin
				last_bit <= mod_bit;
				if (mod_bit != last_bit) run_len <= 8'h1;
				else if (run_len != FAST_RUN) run_len <= run_len + 8'h1;
			end
		end
	end

	a_settle_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R07
		(window_end && !cfg.restart && settled < need - 2'h1) |=> !res.valid)
		else $error("result delivered before settling");
	a_clamp_err: assert property (@(posedge clk) disable iff (!rst_n) // see R15
		(res.valid && res.err) |-> (res.data == 16'h7fff || res.data == 16'h8000))
		else $error("error result not at full scale");

endmodule
`default_nettype wire

// ### sim/dsdc_mod_model.sv
// Purpose: stand-in for both sigma-delta modulators
// Assumes: the block samples a bit on each strobe edge
// Notes: ones high drives current to full positive, voltage to full negative
`timescale 1ns/1ps
`default_nettype none

module dsdc_mod_model (
	// clock and sample strobe
	input wire logic clk,
	input wire logic strobe,
	// stimulus control
	input wire logic ones,
	// bit streams
	output logic i_bit,
	output logic v_bit
);
	// defined levels before the first strobe
	initial begin
		i_bit = 1'b0;
		v_bit = 1'b0;
	end
	// next bit only after the sample edge, so the block never sees a half-changed bit
	always @(posedge clk) begin
		if (strobe) begin
			i_bit <= ones | ~i_bit;
			v_bit <= !ones && !v_bit; // mid scale, or all zeros while ones is high
		end
	end
endmodule

`default_nettype wire

// ### sim/dsdc_tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: registers reached over AXI4-Lite, one access at a time
// Notes: the settling scenario alone runs about 50k clocks
`timescale 1ns/1ps
`default_nettype none

module dual_sigma_delta_adc_digital_control_tb_top import dsdc_pkg::*;;
	logic SYS_CLK, ARST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
	logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, VT_SRC_SEL;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, MOD_STROBE;
	logic I_MOD_BIT, V_MOD_BIT, ATTEN_EN, GROUND_SWITCH_PIN_CONNECT, GROUND_SWITCH_PIN_VIA_RES, EVT_COUNT, EVT_THRESH, ones;
	int errors, compares;

	dsdc_top dut (.*);
	dsdc_mod_model mdl (.clk(SYS_CLK), .strobe(MOD_STROBE), .ones(ones), .i_bit(I_MOD_BIT), .v_bit(V_MOD_BIT));

	// clock at 200 MHz
	initial begin
		SYS_CLK = 1'b0;
		forever #2.5 SYS_CLK = ~SYS_CLK;
	end

	task results;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// write: both channels offered together, bready held until the response
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID && n < 99);
		S_AXI_BREADY <= 1'b0;
		chk("bresp", 32'(r), 32'(S_AXI_BRESP));
		if (n >= 99) begin
			chk("wr_timeout", 32'h0, 32'h1);
			results;
		end
	endtask

	task rdw(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID && n < 99);
		S_AXI_RREADY <= 1'b0;
		chk("rdata", e, S_AXI_RDATA);
		chk("rresp", 32'(r), 32'(S_AXI_RRESP));
		if (n >= 99) begin
			chk("rd_timeout", 32'h0, 32'h1);
			results;
		end
	endtask

	task t_reset;
		rdw(ADDR_CFG, 32'(RST_CFG), RESP_OKAY);
		rdw(ADDR_SHIFT, 32'(RST_SHIFT), RESP_OKAY);
		rdw(ADDR_CLIM, 32'(RST_CLIM), RESP_OKAY);
		rdw(8'hfc, 32'h0, RESP_SLVERR);
		wr(ADDR_CVAL, 32'h5, RESP_SLVERR);
		$display("reset test done");
	endtask

	// every switch combination, every source code, attenuator both ways
	task t_pins;
		int k;
		for (k = 0; k < 4; k++) begin
			wr(ADDR_CFG, 32'(k[1]) << CFG_GND, RESP_OKAY);
			wr(ADDR_MODE, (32'(k[0]) << MODE_RES) | 32'(k), RESP_OKAY);
			wr(ADDR_HV, 32'(k[0]) << HV_ATTEN, RESP_OKAY);
			repeat (3) @(posedge SYS_CLK);
			chk("ground_switch_pin", {k[1] & ~k[0], k[1] & k[0]}, {GROUND_SWITCH_PIN_CONNECT, GROUND_SWITCH_PIN_VIA_RES});
			chk("src", (k == 3) ? 2 : k, 32'(VT_SRC_SEL));
			chk("atten", 32'(k[0]), 32'(ATTEN_EN));
		end
		$display("pin test done");
	endtask

	// current full positive, voltage full negative: chopped settling, threshold one below, accumulate
	task t_conv;
		int n, lo;
		logic thr;
		lo = (2 * DEC_MIN - 1) * MOD_DIV;
		ones <= 1'b1;
		wr(ADDR_IDEC, 32'(DEC_MIN), RESP_OKAY);
		wr(ADDR_VDEC, 32'(DEC_MIN), RESP_OKAY);
		wr(ADDR_SHIFT, 32'h0, RESP_OKAY);
		wr(ADDR_THR, 32'(DEC_MIN) - 1, RESP_OKAY);
		wr(ADDR_CFG, 32'h37, RESP_OKAY);
		thr = 1'b0;
		for (n = 0; n < 60000 && !EVT_COUNT; n++) begin
			@(posedge SYS_CLK);
			thr |= EVT_THRESH;
		end
		chk("settle", 1, 32'(n >= lo && n < lo + 2 * MOD_DIV));
		if (n >= 60000) begin
			chk("settle_timeout", 32'h0, 32'h1);
			results;
		end
		chk("thresh", 1, 32'(thr));
		rdw(ADDR_IRES, 32'(DEC_MIN), RESP_OKAY);
		rdw(ADDR_VRES, 32'h0000ffc0, RESP_OKAY);
		rdw(ADDR_ACC, 32'(DEC_MIN), RESP_OKAY);
		rdw(ADDR_STAT, 32'h7, RESP_OKAY);
		$display("conversion test done");
	endtask

	initial begin
		ARST_N = 1'b0;
		S_AXI_AWVALID = 1'b0;
		S_AXI_WVALID = 1'b0;
		S_AXI_BREADY = 1'b0;
		S_AXI_ARVALID = 1'b0;
		S_AXI_RREADY = 1'b0;
		S_AXI_AWADDR = 8'h00;
		S_AXI_ARADDR = 8'h00;
		S_AXI_WDATA = 32'h0;
		S_AXI_WSTRB = 4'hf;
		ones = 1'b0;
		errors = 0;
		compares = 0;
		repeat (20) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		t_reset;
		t_pins;
		t_conv;
		results;
	end
endmodule

`default_nettype wire
